// >>> hw/trm_terminal_decoder.sv
// Contract
// - two select terminals pick motor one to four
// - every digital terminal is filtered with a 0 to 1000 ms time
// - mode setting picks two-line A, two-line B, three-line A or B
// - mode 0: terminal a runs forward, terminal b runs reverse
// - mode 1: a enables running, b level selects reverse
// - mode 2: c enables, a press latches forward, b press reverse
// - three-line modes stop at once when c drops
// - mode 3: c enables, a press starts, b level gives direction
// - up/down terminals ramp frequency at the programmed rate
// - resolution setting sets the weight of one rate step
// - first analog input maps linearly between two points
// - input above maximum point gives the maximum setting
// - input below minimum point follows the policy bit
// - policy 0 gives minimum setting, policy 1 gives zero
// - current input counts 1 mA as 0.5 V
// - first analog input has a 0 to 10 s filter
// - second analog input has its own curve and filter
`timescale 1ns/1ns
`include "trm_regs.svh"
module trm_terminal_decoder #(
  parameter int TICK_CYCLES = `TRM_TICK_CYCLES,
  parameter int NDI = 7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic commandTerminalA,
  input wire logic commandTerminalB,
  input wire logic commandTerminalC,
  input wire logic motorSelTermOne,
  input wire logic motorSelTermTwo,
  input wire logic upTerm,
  input wire logic downTerm,
  input wire logic [9:0] digitalInputFilterTime,
  input wire trm_pkg::trm_mode_e terminalCommandModeSel,
  input wire logic [15:0] updownRampRate,
  input wire logic [1:0] frequencyResolutionSel,
  input wire logic [10:0] analogVoltageInputOne,
  input wire logic [10:0] analogSecondInput,
  input wire logic [1:0] analogIsCurrent,
  input wire trm_pkg::trm_volt_t curveOneMinInput,
  input wire trm_pkg::trm_volt_t curveOneMaxInput,
  input wire trm_pkg::trm_pct_t curveOneMinSetting,
  input wire trm_pkg::trm_pct_t curveOneMaxSetting,
  input wire logic [9:0] analogOneFilterTime,
  input wire trm_pkg::trm_volt_t curveTwoMinInput,
  input wire trm_pkg::trm_volt_t curveTwoMaxInput,
  input wire trm_pkg::trm_pct_t curveTwoMinSetting,
  input wire trm_pkg::trm_pct_t curveTwoMaxSetting,
  input wire logic [9:0] analogTwoFilterTime,
  input wire logic [1:0] belowMinimumPolicy,
  output logic forwardRunCmd,
  output logic reverseRunCmd,
  output logic [1:0] selectedMotor,
  output logic [NDI-1:0] terminalStatus,
  output logic signed [31:0] updownFreqOffset,
  output trm_pkg::trm_pct_t analogOneSetting,
  output trm_pkg::trm_pct_t analogTwoSetting
);

  // ==========================================================
  // millisecond tick
  logic [15:0] tickCnt_r;
  logic msTick_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b0;
    end else if (tickCnt_r == 16'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 16'h0001;
      msTick_r <= 1'b0;
    end
  end

  // ==========================================================
  // terminal filters
  logic [NDI-1:0] rawVec;
  logic [NDI-1:0] diStable_r;
  logic [9:0] diCnt_r [NDI];
  logic [9:0] filtEff;

  assign rawVec = {downTerm, upTerm, motorSelTermTwo, motorSelTermOne,
                   commandTerminalC, commandTerminalB, commandTerminalA};
  assign filtEff = (digitalInputFilterTime > `TRM_DI_FILT_MAX_MS) ?
                   `TRM_DI_FILT_MAX_MS : digitalInputFilterTime;

  // a level must differ for the whole filter time before it is taken;
  // any bounce back resets the count
  for (genvar i = 0; i < NDI; i++) begin : g_di
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        diStable_r[i] <= 1'b0;
        diCnt_r[i] <= 10'h000;
      end else if (rawVec[i] == diStable_r[i]) begin
        diCnt_r[i] <= 10'h000;
      end else if (diCnt_r[i] >= filtEff) begin
        diStable_r[i] <= rawVec[i];
        diCnt_r[i] <= 10'h000;
      end else if (msTick_r) begin
        diCnt_r[i] <= diCnt_r[i] + 10'h001;
      end
    end
  end

  assign terminalStatus = diStable_r;

  logic termA;
  logic termB;
  logic termC;
  logic termUp;
  logic termDown;

  assign termA = diStable_r[0];
  assign termB = diStable_r[1];
  assign termC = diStable_r[2];
  assign termUp = diStable_r[5];
  assign termDown = diStable_r[6];

  // ==========================================================
  // motor select
  logic [1:0] motor_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_r <= 2'h0;
    end else begin
      motor_r <= {diStable_r[4], diStable_r[3]};
    end
  end

  assign selectedMotor = motor_r;

  // ==========================================================
  // run command decode
  logic prevA_r;
  logic prevB_r;
  logic riseA;
  logic riseB;
  logic latchRun_r;
  logic latchRun_nxt;
  logic latchRev_r;
  logic latchRev_nxt;
  logic fwd_r;
  logic fwd_nxt;
  logic rev_r;
  logic rev_nxt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevA_r <= 1'b0;
      prevB_r <= 1'b0;
    end else begin
      prevA_r <= termA;
      prevB_r <= termB;
    end
  end

  assign riseA = termA & ~prevA_r;
  assign riseB = termB & ~prevB_r;

  always_comb begin
    latchRun_nxt = 1'b0;
    latchRev_nxt = latchRev_r;
    fwd_nxt = 1'b0;
    rev_nxt = 1'b0;
    case (terminalCommandModeSel)
      trm_pkg::TRM_TWO_LINE_A: begin
        fwd_nxt = termA & ~termB;
        rev_nxt = termB & ~termA;
      end
      trm_pkg::TRM_TWO_LINE_B: begin
        fwd_nxt = termA & ~termB;
        rev_nxt = termA & termB;
      end
      trm_pkg::TRM_THREE_LINE_A: begin
        if (!termC) begin
          latchRun_nxt = 1'b0;
        end else if (riseA) begin
          latchRun_nxt = 1'b1;
          latchRev_nxt = 1'b0;
        end else if (riseB) begin
          latchRun_nxt = 1'b1;
          latchRev_nxt = 1'b1;
        end else begin
          latchRun_nxt = latchRun_r;
        end
        fwd_nxt = latchRun_nxt & ~latchRev_nxt;
        rev_nxt = latchRun_nxt & latchRev_nxt;
      end
      trm_pkg::TRM_THREE_LINE_B: begin
        if (!termC) begin
          latchRun_nxt = 1'b0;
        end else if (riseA) begin
          latchRun_nxt = 1'b1;
        end else begin
          latchRun_nxt = latchRun_r;
        end
        latchRev_nxt = termB;
        fwd_nxt = latchRun_nxt & ~termB;
        rev_nxt = latchRun_nxt & termB;
      end
      default: begin
        latchRun_nxt = 1'b0;
      end
    endcase
  end

  // switching to a two-line mode drops the latch, so a later return never
  // resumes a run that nobody pressed for
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latchRun_r <= 1'b0;
      latchRev_r <= 1'b0;
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      latchRun_r <= latchRun_nxt;
      latchRev_r <= latchRev_nxt;
      fwd_r <= fwd_nxt;
      rev_r <= rev_nxt;
    end
  end

  assign forwardRunCmd = fwd_r;
  assign reverseRunCmd = rev_r;

  // ==========================================================
  // up/down frequency ramp
  logic [15:0] rateEff;
  logic [3:0] rateScale;
  logic [20:0] stepVal;
  logic signed [32:0] offsSum;
  logic signed [31:0] offs_r;

  assign rateEff = (updownRampRate == 16'h0000) ? 16'h0001 : updownRampRate;
  assign rateScale = (frequencyResolutionSel == `TRM_RES_THOUSANDTH) ?
                     `TRM_RES2_SCALE : `TRM_RES1_SCALE;
  assign stepVal = 21'(rateEff) * 21'(rateScale);

  always_comb begin
    offsSum = 33'(offs_r);
    if (termUp && !termDown) begin
      offsSum = 33'(offs_r) + $signed({12'h000, stepVal});
    end else if (termDown && !termUp) begin
      offsSum = 33'(offs_r) - $signed({12'h000, stepVal});
    end
  end

  // saturates rather than wraps: a held button must not flip the sign
  // ramp rate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      offs_r <= 32'sh00000000;
    end else if (msTick_r) begin
      if (offsSum > `TRM_OFFS_MAX) begin
        offs_r <= 32'sh7FFFFFFF;
      end else if (offsSum < `TRM_OFFS_MIN) begin
        offs_r <= 32'sh80000000;
      end else begin
        offs_r <= offsSum[31:0];
      end
    end
  end

  assign updownFreqOffset = offs_r;

  // ==========================================================
  // analog inputs
  logic [10:0] aiRaw [2];
  trm_pkg::trm_volt_t aiMin [2];
  trm_pkg::trm_volt_t aiMax [2];
  trm_pkg::trm_pct_t aiMinSet [2];
  trm_pkg::trm_pct_t aiMaxSet [2];
  logic [9:0] aiFilt [2];
  trm_pkg::trm_pct_t aiOut [2];

  assign aiRaw[0] = analogVoltageInputOne;
  assign aiRaw[1] = analogSecondInput;
  assign aiMin[0] = curveOneMinInput;
  assign aiMin[1] = curveTwoMinInput;
  assign aiMax[0] = curveOneMaxInput;
  assign aiMax[1] = curveTwoMaxInput;
  assign aiMinSet[0] = curveOneMinSetting;
  assign aiMinSet[1] = curveTwoMinSetting;
  assign aiMaxSet[0] = curveOneMaxSetting;
  assign aiMaxSet[1] = curveTwoMaxSetting;
  assign aiFilt[0] = (analogOneFilterTime > `TRM_AI_FILT_MAX_10MS) ?
                     `TRM_AI_FILT_MAX_10MS : analogOneFilterTime;
  assign aiFilt[1] = (analogTwoFilterTime > `TRM_AI_FILT_MAX_10MS) ?
                     `TRM_AI_FILT_MAX_10MS : analogTwoFilterTime;

  for (genvar c = 0; c < 2; c++) begin : g_ai
    trm_analog_curve u_curve (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .msTick(msTick_r),
      .rawIn(aiRaw[c]),
      .isCurrent(analogIsCurrent[c]),
      .minIn(aiMin[c]),
      .maxIn(aiMax[c]),
      .minSet(aiMinSet[c]),
      .maxSet(aiMaxSet[c]),
      .filtTime(aiFilt[c]),
      .belowMinZero(belowMinimumPolicy[c]),
      .setting_r(aiOut[c])
    );
  end

  assign analogOneSetting = aiOut[0];
  assign analogTwoSetting = aiOut[1];

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_mode3a_press;
    terminalCommandModeSel == trm_pkg::TRM_THREE_LINE_A && termC && riseA && !riseB;
  endsequence
  sequence s_mode3a_hold;
    terminalCommandModeSel == trm_pkg::TRM_THREE_LINE_A && termC && !riseA && !riseB;
  endsequence

  AST_MOTOR_SEL: assert property (
    $stable(diStable_r[4:3]) |=> selectedMotor == {$past(diStable_r[4]), $past(diStable_r[3])})
    else $error("motor select does not follow terminals");
  AST_DI_FILTER: assert property (
    $changed(diStable_r[0]) |-> $past(diCnt_r[0]) >= $past(filtEff))
    else $error("terminal taken before filter time");
  AST_TWO_A_FWD: assert property (
    terminalCommandModeSel == trm_pkg::TRM_TWO_LINE_A && termA && !termB
      |=> forwardRunCmd && !reverseRunCmd)
    else $error("two-line A forward missing");
  AST_TWO_A_STOP: assert property (
    terminalCommandModeSel == trm_pkg::TRM_TWO_LINE_A && termA == termB
      |=> !forwardRunCmd && !reverseRunCmd)
    else $error("two-line A conflict not stopped");
  AST_TWO_B_REV: assert property (
    terminalCommandModeSel == trm_pkg::TRM_TWO_LINE_B && termA && termB
      |=> reverseRunCmd && !forwardRunCmd)
    else $error("two-line B reverse missing");
  AST_THREE_STOP: assert property (
    terminalCommandModeSel[1] && !termC |=> !forwardRunCmd && !reverseRunCmd)
    else $error("three-line run without enable");
  AST_THREE_A_LATCH: assert property (
    s_mode3a_press ##1 s_mode3a_hold |=> forwardRunCmd && !reverseRunCmd)
    else $error("three-line A forward not latched");
  AST_THREE_B_DIR: assert property (
    terminalCommandModeSel == trm_pkg::TRM_THREE_LINE_B && termC && latchRun_r
      && termB |=> reverseRunCmd)
    else $error("three-line B direction wrong");
  AST_UPDOWN_STEP: assert property (
    msTick_r && termUp && !termDown && offs_r < 32'sh40000000
      |=> updownFreqOffset == $past(offs_r) + $signed({11'h000, $past(stepVal)}))
    else $error("up ramp step wrong");
endmodule

// >>> hw/trm_regs.svh
`ifndef TRM_REGS_SVH
`define TRM_REGS_SVH
// ==========================================================
// timing
`define TRM_CLK_HZ 20000000
`define TRM_TICK_US 1000
`define TRM_TICK_CYCLES ((`TRM_CLK_HZ / 1000000) * `TRM_TICK_US)
// ==========================================================
// digital filter, in ms
`define TRM_DI_FILT_DEF_MS 10
`define TRM_DI_FILT_MAX_MS 10'h3E8
// ==========================================================
// analog, volts in 10 mV, percent in 0.1 %, time in 10 ms
`define TRM_AI_FULL_SCALE 10'h3E8
`define TRM_AI_VOLT_CLAMP 11'h3E8
`define TRM_AI_FILT_DEF_10MS 10
`define TRM_AI_FILT_MAX_10MS 10'h3E8
`define TRM_AI_MS_PER_UNIT 14'hA
`define TRM_AI_FRAC_BITS 16
`define TRM_PCT_FULL 11'h3E8
// ==========================================================
// up/down ramp, accumulator in micro-hertz
`define TRM_RATE_DEF_RES1 100
`define TRM_RATE_DEF_RES2 1000
`define TRM_RES_THOUSANDTH 2'h2
`define TRM_RES1_SCALE 4'hA
`define TRM_RES2_SCALE 4'h1
`define TRM_OFFS_MAX 33'sh07FFFFFFF
`define TRM_OFFS_MIN -33'sh080000000
`endif

// >>> hw/trm_pkg.sv
package trm_pkg;
  typedef enum logic [1:0] {
    TRM_TWO_LINE_A = 2'b00,
    TRM_TWO_LINE_B = 2'b01,
    TRM_THREE_LINE_A = 2'b10,
    TRM_THREE_LINE_B = 2'b11
  } trm_mode_e;
  typedef logic signed [10:0] trm_pct_t;
  typedef logic [9:0] trm_volt_t;
endpackage

// >>> hw/trm_analog_curve.sv
`timescale 1ns/1ns
`include "trm_regs.svh"
module trm_analog_curve (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic msTick,
  input wire logic [10:0] rawIn,
  input wire logic isCurrent,
  input wire trm_pkg::trm_volt_t minIn,
  input wire trm_pkg::trm_volt_t maxIn,
  input wire trm_pkg::trm_pct_t minSet,
  input wire trm_pkg::trm_pct_t maxSet,
  input wire logic [9:0] filtTime,
  input wire logic belowMinZero,
  output trm_pkg::trm_pct_t setting_r
);
  localparam int FB = `TRM_AI_FRAC_BITS;
  // ==========================================================
  // scaling and filter
  logic [10:0] half;
  logic [9:0] volt;
  logic [13:0] timeMs;
  logic [3:0] shiftK;
  logic [25:0] acc_r;
  logic signed [27:0] diff;
  trm_pkg::trm_volt_t filtV;
  assign half = isCurrent ? {1'b0, rawIn[10:1]} : rawIn;
  assign volt = (half > `TRM_AI_VOLT_CLAMP) ? `TRM_AI_FULL_SCALE : half[9:0];
  assign timeMs = 14'(filtTime) * `TRM_AI_MS_PER_UNIT;
  // time constant rounded down to a power of two, keeps the filter divider-free
  always_comb begin
    shiftK = 4'h0;
    for (int i = 1; i < 14; i++) begin
      if (timeMs[i]) begin
        shiftK = 4'(i);
      end
    end
  end
  assign diff = $signed({2'b00, volt, 16'h0000}) - $signed({2'b00, acc_r});
  assign filtV = acc_r[25:FB];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 26'h0000000;
    end else if (filtTime == 10'h000) begin
      acc_r <= {volt, 16'h0000};
    end else if (msTick) begin
      acc_r <= 26'($signed({2'b00, acc_r}) + (diff >>> shiftK));
    end
  end
  // ==========================================================
  // two point curve
  trm_pkg::trm_volt_t effMax;
  trm_pkg::trm_volt_t effMin;
  logic signed [23:0] prod;
  logic signed [23:0] quot;
  trm_pkg::trm_pct_t setting_nxt;
  assign effMax = (maxIn > `TRM_AI_FULL_SCALE) ? `TRM_AI_FULL_SCALE : maxIn;
  assign effMin = (minIn > effMax) ? effMax : minIn;
  assign prod = $signed({14'h0000, filtV - effMin}) * (24'(maxSet) - 24'(minSet));
  assign quot = prod / $signed({14'h0000, effMax - effMin});
  always_comb begin
    setting_nxt = 11'(24'(minSet) + quot);
    if (filtV >= effMax) begin
      setting_nxt = maxSet;
    end else if (filtV < effMin) begin
      setting_nxt = belowMinZero ? 11'sh000 : minSet;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setting_r <= 11'sh000;
    end else begin
      setting_r <= setting_nxt;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_ABOVE_MAX: assert property (
    (filtV > effMax) && $stable(maxSet) |=> setting_r == $past(maxSet))
    else $error("setting not held at curve maximum");
  AST_BELOW_MIN: assert property (
    (filtV < effMin) && belowMinZero |=> setting_r == 11'sh000)
    else $error("below minimum setting not zero");
  AST_POINT_ORDER: assert property (
    effMin <= effMax)
    else $error("curve points out of order");
endmodule

// >>> testbench/trm_switch_model.sv
`timescale 1ns/1ns
// ==========================================================
// switches and push buttons on the terminal strip
module trm_switch_model (
  input wire logic sys_clk,
  output logic termA,
  output logic termB,
  output logic termC,
  output logic selOne,
  output logic selTwo,
  output logic termUp,
  output logic termDown
);
  // order {down,up,sel2,sel1,c,b,a}, same as the filtered status
  // enable holds its level until the bench sets a new one
  // the enable contact only moves when the bench says so; the three-line test opens it while a run is latched
  logic [6:0] lvl = 7'h00;
  assign termA = lvl[0];
  assign termB = lvl[1];
  assign termC = lvl[2];
  assign selOne = lvl[3];
  assign selTwo = lvl[4];
  assign termUp = lvl[5];
  assign termDown = lvl[6];
  task automatic setAll(input logic [6:0] v);
    @(posedge sys_clk);
    #2 lvl = v;
  endtask
  // a push button closes for n cycles, then springs back
  task automatic press(input int idx, input int n);
    @(posedge sys_clk);
    #2 lvl[idx] = ~lvl[idx];
    repeat (n) @(posedge sys_clk);
    #2 lvl[idx] = ~lvl[idx];
  endtask
endmodule

// >>> testbench/test_trm_terminal_decoder.sv
`timescale 1ns/1ns
module test_trm_terminal_decoder;
  // short tick keeps the millisecond counts cheap in simulation
  localparam int TICK = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] diFilt = 10'h000;
  trm_pkg::trm_mode_e mode = trm_pkg::TRM_TWO_LINE_A;
  logic [15:0] rate = 16'h0064;
  logic [1:0] res = 2'h1;
  logic [10:0] ain1 = 11'h000;
  logic [10:0] ain2 = 11'h000;
  logic [1:0] isCur = 2'h0;
  logic [1:0] policy = 2'h0;
  trm_pkg::trm_volt_t mn = 10'h000;
  trm_pkg::trm_volt_t mx = 10'h3E8;
  trm_pkg::trm_pct_t lo = 11'sh000;
  trm_pkg::trm_pct_t hi = 11'sh3E8;
  trm_pkg::trm_volt_t mn2 = 10'h000;
  trm_pkg::trm_volt_t mx2 = 10'h3E8;
  trm_pkg::trm_pct_t lo2 = 11'sh000;
  trm_pkg::trm_pct_t hi2 = 11'sh3E8;
  logic [9:0] af1 = 10'h000;
  logic [9:0] af2 = 10'h000;
  logic tA, tB, tC, s1, s2, tU, tD, forward_run_cmd, reverse_run_cmd;
  logic [1:0] motor;
  logic [6:0] status;
  logic signed [31:0] offs;
  logic signed [31:0] o0;
  trm_pkg::trm_pct_t pct1, pct2;
  int miscompares = 0;
  int checksDone = 0;
  always #25 sys_clk = ~sys_clk;
  trm_switch_model trm_switch_model_i (.sys_clk(sys_clk), .termA(tA), .termB(tB),
    .termC(tC), .selOne(s1), .selTwo(s2), .termUp(tU), .termDown(tD));
  trm_terminal_decoder #(.TICK_CYCLES(TICK), .NDI(7)) trm_terminal_decoder_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .commandTerminalA(tA), .commandTerminalB(tB),
    .commandTerminalC(tC), .motorSelTermOne(s1), .motorSelTermTwo(s2), .upTerm(tU),
    .downTerm(tD), .digitalInputFilterTime(diFilt), .terminalCommandModeSel(mode),
    .updownRampRate(rate), .frequencyResolutionSel(res), .analogVoltageInputOne(ain1),
    .analogSecondInput(ain2), .analogIsCurrent(isCur), .curveOneMinInput(mn),
    .curveOneMaxInput(mx), .curveOneMinSetting(lo), .curveOneMaxSetting(hi),
    .analogOneFilterTime(af1), .curveTwoMinInput(mn2), .curveTwoMaxInput(mx2),
    .curveTwoMinSetting(lo2), .curveTwoMaxSetting(hi2), .analogTwoFilterTime(af2),
    .belowMinimumPolicy(policy), .forwardRunCmd(forward_run_cmd), .reverseRunCmd(reverse_run_cmd),
    .selectedMotor(motor), .terminalStatus(status), .updownFreqOffset(offs),
    .analogOneSetting(pct1), .analogTwoSetting(pct2));
  // ==========================================================
  // shared helpers
  task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic setMode(input trm_pkg::trm_mode_e m);
    @(posedge sys_clk);
    #2 mode = m;
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic testMotor();
    for (int i = 0; i < 4; i++) begin
      trm_switch_model_i.setAll({2'b00, i[1:0], 3'b000});
      waitCyc(3);
      check(motor, i);
      check(status, {2'b00, i[1:0], 3'b000});
    end
    $display("motor select done");
  endtask
  task automatic testTwoLine();
    for (int m = 0; m < 2; m++) begin
      setMode(m ? trm_pkg::TRM_TWO_LINE_B : trm_pkg::TRM_TWO_LINE_A);
      for (int i = 0; i < 4; i++) begin
        trm_switch_model_i.setAll({5'h00, i[1:0]});
        waitCyc(3);
        if (m == 0)
          check({forward_run_cmd, reverse_run_cmd}, {i == 1, i == 2});
        else
          check({forward_run_cmd, reverse_run_cmd}, {i == 1, i == 3});
      end
    end
    $display("two-line modes done");
  endtask
  task automatic testThreeLine();
    setMode(trm_pkg::TRM_THREE_LINE_A);
    trm_switch_model_i.setAll(7'h04);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b00);
    trm_switch_model_i.press(0, 3);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b10);
    trm_switch_model_i.press(1, 3);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b01);
    trm_switch_model_i.setAll(7'h00);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b00);
    trm_switch_model_i.press(0, 3);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b00);
    setMode(trm_pkg::TRM_THREE_LINE_B);
    trm_switch_model_i.setAll(7'h04);
    trm_switch_model_i.press(0, 3);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b10);
    trm_switch_model_i.setAll(7'h06);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b01);
    trm_switch_model_i.setAll(7'h02);
    waitCyc(3);
    check({forward_run_cmd, reverse_run_cmd}, 2'b00);
    trm_switch_model_i.setAll(7'h00);
    $display("three-line modes done");
  endtask
  task automatic testFilter();
    @(posedge sys_clk);
    #2 diFilt = 10'h002;
    waitCyc(20);
    // a 3-cycle bounce is well under two ticks of 4 cycles
    trm_switch_model_i.press(0, 3);
    waitCyc(20);
    check(status[0], 1'b0);
    trm_switch_model_i.setAll(7'h01);
    waitCyc(5);
    check(status[0], 1'b0);
    waitCyc(15);
    check(status[0], 1'b1);
    trm_switch_model_i.setAll(7'h00);
    #2 diFilt = 10'h000;
    waitCyc(20);
    $display("terminal filter done");
  endtask
  task automatic testUpDown();
    // 40 cycles are exactly ten ticks, sampled at the same phase
    trm_switch_model_i.setAll(7'h20);
    waitCyc(8);
    o0 = offs;
    waitCyc(40);
    check(offs - o0, 32'sd10000);
    @(posedge sys_clk);
    #2 res = 2'h2;
    trm_switch_model_i.setAll(7'h40);
    waitCyc(8);
    o0 = offs;
    waitCyc(40);
    check(offs - o0, -32'sd1000);
    trm_switch_model_i.setAll(7'h60);
    waitCyc(8);
    o0 = offs;
    waitCyc(40);
    check(offs - o0, 32'sd0);
    // a second rate proves the step really follows the programmed value
    @(posedge sys_clk);
    #2 rate = 16'h00FA;
    res = 2'h1;
    trm_switch_model_i.setAll(7'h20);
    waitCyc(8);
    o0 = offs;
    waitCyc(40);
    check(offs - o0, 32'sd25000);
    trm_switch_model_i.setAll(7'h00);
    $display("up/down ramp done");
  endtask
  task automatic ana(input int a, input int b, input int l, input int h, input int v,
                     input logic cur, input logic pol, input int exp);
    @(posedge sys_clk);
    #2;
    mn = a[9:0];
    mx = b[9:0];
    lo = l[10:0];
    hi = h[10:0];
    mn2 = a[9:0];
    mx2 = b[9:0];
    lo2 = l[10:0];
    hi2 = h[10:0];
    ain1 = v[10:0];
    ain2 = v[10:0];
    isCur = {cur, cur};
    policy = {pol, pol};
    waitCyc(4);
    check(pct1, exp);
    check(pct2, exp);
  endtask
  task automatic testAnalog();
    ana(0, 1000, 0, 1000, 500, 1'b0, 1'b0, 500);
    ana(100, 800, -200, 600, 450, 1'b0, 1'b0, 200);
    ana(100, 800, -200, 600, 900, 1'b0, 1'b0, 600);
    ana(100, 800, -200, 600, 50, 1'b0, 1'b0, -200);
    ana(100, 800, -200, 600, 50, 1'b0, 1'b1, 0);
    ana(100, 800, -200, 600, 900, 1'b1, 1'b0, 200);
    ana(900, 800, -200, 600, 700, 1'b0, 1'b0, -200);
    ana(900, 800, -200, 600, 850, 1'b0, 1'b0, 600);
    // channels set apart: own curve, own current bit, own policy bit
    @(posedge sys_clk);
    #2;
    mn = 10'h190;
    mx = 10'h3E8;
    lo = 11'sh6D4;
    hi = 11'sh3E8;
    mn2 = 10'h0C8;
    mx2 = 10'h258;
    lo2 = 11'sh418;
    hi2 = 11'sh3E8;
    ain1 = 11'h12C;
    ain2 = 11'h3E8;
    isCur = 2'h2;
    policy = 2'h1;
    waitCyc(4);
    check(pct1, 32'sd0);
    check(pct2, 32'sd500);
    ana(0, 1000, 0, 1000, 0, 1'b0, 1'b0, 0);
    @(posedge sys_clk);
    #2;
    af1 = 10'h00A;
    ain1 = 11'h3E8;
    ain2 = 11'h3E8;
    waitCyc(12);
    check(pct1 > 0 && pct1 < 11'sh3E8, 1'b1);
    check(pct2, 32'sd1000);
    @(posedge sys_clk);
    #2;
    af2 = 10'h00A;
    ain2 = 11'h000;
    waitCyc(12);
    check(pct2 > 0 && pct2 < 11'sh3E8, 1'b1);
    $display("analog curves done");
  endtask
  // ==========================================================
  // run
  initial begin
    repeat (10) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    waitCyc(2);
    testMotor();
    testTwoLine();
    testThreeLine();
    testFilter();
    testUpDown();
    testAnalog();
    end_sim();
  end
  // whole run takes under 1000 cycles, so this is a wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
